// ===== core/alu_params.svh
`ifndef ALU_PARAMS_SVH
`define ALU_PARAMS_SVH
// register byte addresses
`define ALU_OFF_CMD 8'h00
`define ALU_OFF_ACC 8'h04
`define ALU_OFF_FILE 8'h08
`define ALU_OFF_STATUS 8'h0c
`define ALU_OFF_PORTA 8'h10
`define ALU_OFF_PORTB 8'h14
`define ALU_OFF_PORTC 8'h18
`define ALU_OFF_WDOG 8'h1c
// command word fields
`define ALU_CMD_OP_LSB 0
`define ALU_CMD_DEST_BIT 4
`define ALU_CMD_LIT_LSB 8
`define ALU_CMD_ADDR_LSB 16
// status fields
`define ALU_ST_CARRY 0
`define ALU_ST_NIB 1
`define ALU_ST_ZERO 2
`define ALU_ST_PD 3
`define ALU_ST_TO 4
`define ALU_ST_SLEEP 5
// direction operands
`define ALU_DIR_A 8'h05
`define ALU_DIR_B 8'h06
`define ALU_DIR_C 8'h07
// reset values
`define ALU_RST_DIR 8'hff
`define ALU_RST_STATUS 6'h18
`define ALU_WDOG_CLEAR 8'h00
`endif

// ===== core/alu_pkg.sv
package alu_pkg;
	typedef enum logic [3:0] {
		ALU_OP_NOP,
		ALU_OP_ROTR,
		ALU_OP_LITSUB,
		ALU_OP_FILESUB,
		ALU_OP_FILESUBB,
		ALU_OP_SWAP,
		ALU_OP_XORLIT,
		ALU_OP_DIR,
		ALU_OP_XORFILE,
		ALU_OP_SLEEP
	} alu_op_t;
endpackage

// ===== core/alu_core.sv
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps
`include "alu_params.svh"
module alu_core #(
	parameter int ADDR_W = 7,
	parameter int PRE_W = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic wake,
	output logic osc_stop
);
	// ==================================================
	// state
	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] file_data;
		logic [ADDR_W-1:0] file_addr;
		logic carry;
		logic nib;
		logic zero;
		logic pd_n;
		logic to_n;
		logic sleeping;
		logic [7:0] dir_a;
		logic [7:0] dir_b;
		logic [7:0] dir_c;
		logic [7:0] wdog;
		logic [PRE_W-1:0] pre;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
	} alu_state_t;

	alu_state_t s_reg;
	alu_state_t s_next;

	// ==================================================
	// bus decode
	logic addr_ph;
	assign addr_ph = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_reg.rdata;
	assign osc_stop = s_reg.sleeping;

	// read mux, unmapped reads as zero
	function automatic logic [31:0] rd_mux(input alu_state_t s, input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		if (a == `ALU_OFF_ACC) begin
			r = {24'h000000, s.acc};
		end else if (a == `ALU_OFF_FILE) begin
			r = {8'h00, 8'(s.file_addr), 8'h00, s.file_data};
		end else if (a == `ALU_OFF_STATUS) begin
			r = {26'h0, s.sleeping, s.to_n, s.pd_n, s.zero, s.nib, s.carry};
		end else if (a == `ALU_OFF_PORTA) begin
			r = {24'h000000, s.dir_a};
		end else if (a == `ALU_OFF_PORTB) begin
			r = {24'h000000, s.dir_b};
		end else if (a == `ALU_OFF_PORTC) begin
			r = {24'h000000, s.dir_c};
		end else if (a == `ALU_OFF_WDOG) begin
			r = {24'h000000, s.wdog};
		end
		return r;
	endfunction

	// ==================================================
	// execute and register access
	logic [3:0] op_raw;
	logic dest;
	logic [7:0] lit;
	logic [8:0] diff;
	logic [4:0] ndiff;
	logic [7:0] res;
	logic borrow_in;
	always_comb begin
		s_next = s_reg;
		op_raw = hwdata[`ALU_CMD_OP_LSB +: 4];
		dest = hwdata[`ALU_CMD_DEST_BIT];
		lit = hwdata[`ALU_CMD_LIT_LSB +: 8];
		diff = 9'h000;
		ndiff = 5'h00;
		res = 8'h00;
		borrow_in = 1'b0;
		// watchdog keeps running while awake; prescaler carries into counter
		if (!s_reg.sleeping) begin
			s_next.pre = s_reg.pre + PRE_W'(1);
			if (&s_reg.pre) begin
				s_next.wdog = s_reg.wdog + 8'h01;
			end
		end
		if (s_reg.sleeping && wake) begin
			s_next.sleeping = 1'b0;
		end
		if (addr_ph) begin
			s_next.wr_pend = hwrite;
			s_next.wr_addr = haddr[7:0];
		end else begin
			s_next.wr_pend = 1'b0;
		end
		if (addr_ph && !hwrite) begin
			s_next.rdata = rd_mux(s_reg, haddr[7:0]);
		end
		if (s_reg.wr_pend) begin
			if (s_reg.wr_addr == `ALU_OFF_ACC) begin
				s_next.acc = hwdata[7:0];
			end else if (s_reg.wr_addr == `ALU_OFF_FILE) begin
				s_next.file_data = hwdata[7:0];
				s_next.file_addr = hwdata[8 +: ADDR_W];
			end else if (s_reg.wr_addr == `ALU_OFF_STATUS) begin
				s_next.carry = hwdata[`ALU_ST_CARRY];
				s_next.nib = hwdata[`ALU_ST_NIB];
				s_next.zero = hwdata[`ALU_ST_ZERO];
			end else if (s_reg.wr_addr == `ALU_OFF_CMD && !s_reg.sleeping) begin
				// subtraction: minuend minus subtrahend, carry = no borrow
				case (op_raw)
					4'(alu_pkg::ALU_OP_ROTR): begin
						res = {s_reg.carry, s_reg.file_data[7:1]};
						s_next.carry = s_reg.file_data[0];
					end
					4'(alu_pkg::ALU_OP_LITSUB): begin
						diff = {1'b0, lit} - {1'b0, s_reg.acc};
						ndiff = {1'b0, lit[3:0]} - {1'b0, s_reg.acc[3:0]};
						res = diff[7:0];
					end
					4'(alu_pkg::ALU_OP_FILESUB), 4'(alu_pkg::ALU_OP_FILESUBB): begin
						borrow_in = (op_raw == 4'(alu_pkg::ALU_OP_FILESUBB)) && !s_reg.carry;
						diff = {1'b0, s_reg.file_data} - {1'b0, s_reg.acc} - {8'h00, borrow_in};
						ndiff = {1'b0, s_reg.file_data[3:0]} - {1'b0, s_reg.acc[3:0]}
							- {4'h0, borrow_in};
						res = diff[7:0];
					end
					4'(alu_pkg::ALU_OP_SWAP): begin
						res = {s_reg.file_data[3:0], s_reg.file_data[7:4]};
					end
					4'(alu_pkg::ALU_OP_XORLIT), 4'(alu_pkg::ALU_OP_XORFILE): begin
						res = s_reg.acc ^ ((op_raw == 4'(alu_pkg::ALU_OP_XORLIT)) ? lit
							: s_reg.file_data);
						s_next.zero = (res == 8'h00);
					end
					4'(alu_pkg::ALU_OP_DIR): begin
						if (lit == `ALU_DIR_A) begin
							s_next.dir_a = s_reg.acc;
						end else if (lit == `ALU_DIR_B) begin
							s_next.dir_b = s_reg.acc;
						end else if (lit == `ALU_DIR_C) begin
							s_next.dir_c = s_reg.acc;
						end
					end
					4'(alu_pkg::ALU_OP_SLEEP): begin
						s_next.pd_n = 1'b0;
						s_next.to_n = 1'b1;
						s_next.wdog = `ALU_WDOG_CLEAR;
						s_next.pre = '0;
						s_next.sleeping = 1'b1;
					end
					default: begin
					end
				endcase
				if (op_raw == 4'(alu_pkg::ALU_OP_LITSUB) || op_raw == 4'(alu_pkg::ALU_OP_FILESUB)
					|| op_raw == 4'(alu_pkg::ALU_OP_FILESUBB)) begin
					s_next.carry = !diff[8];
					s_next.nib = !ndiff[4];
					s_next.zero = (res == 8'h00);
				end
				// destination select; literal ops always go to acc
				if (op_raw == 4'(alu_pkg::ALU_OP_LITSUB) || op_raw == 4'(alu_pkg::ALU_OP_XORLIT)) begin
					s_next.acc = res;
				end else if (op_raw inside {4'(alu_pkg::ALU_OP_ROTR), 4'(alu_pkg::ALU_OP_FILESUB),
					4'(alu_pkg::ALU_OP_FILESUBB), 4'(alu_pkg::ALU_OP_SWAP),
					4'(alu_pkg::ALU_OP_XORFILE)}) begin
					if (dest) begin
						s_next.file_data = res;
					end else begin
						s_next.acc = res;
					end
				end
			end
		end
	end

	// ==================================================
	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg <= '0;
			// flags leave reset as one field, in the same order as the status word
			{s_reg.sleeping, s_reg.to_n, s_reg.pd_n, s_reg.zero, s_reg.nib, s_reg.carry} <=
				`ALU_RST_STATUS;
			s_reg.dir_a <= `ALU_RST_DIR;
			s_reg.dir_b <= `ALU_RST_DIR;
			s_reg.dir_c <= `ALU_RST_DIR;
		end else begin
			s_reg <= s_next;
		end
	end

	// ==================================================
	// checks
	logic cmd_wr;
	assign cmd_wr = s_reg.wr_pend && s_reg.wr_addr == `ALU_OFF_CMD && !s_reg.sleeping;

	sequence sq_sleep_cmd;
		cmd_wr && op_raw == 4'(alu_pkg::ALU_OP_SLEEP);
	endsequence
	sequence sq_asleep;
		!s_reg.pd_n && s_reg.to_n && s_reg.wdog == 8'h00 && osc_stop;
	endsequence

	AST_SLEEP_EFFECT: assert property (@(posedge hclk) disable iff (!hresetn)
		sq_sleep_cmd |=> sq_asleep) else $error("power-down effects missing");
	AST_SLEEP_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
		osc_stop && !wake |=> osc_stop && $stable(s_reg.wdog)) else $error("sleep left");
	AST_ROTR: assert property (@(posedge hclk) disable iff (!hresetn)
		cmd_wr && op_raw == 4'(alu_pkg::ALU_OP_ROTR) |=> s_reg.carry == $past(s_reg.file_data[0])
		&& $stable(s_reg.zero)) else $error("rotate carry wrong");
	AST_DEST: assert property (@(posedge hclk) disable iff (!hresetn)
		cmd_wr && op_raw == 4'(alu_pkg::ALU_OP_SWAP) && dest |=> $stable(s_reg.acc))
		else $error("destination wrong");
	AST_LITSUB: assert property (@(posedge hclk) disable iff (!hresetn)
		cmd_wr && op_raw == 4'(alu_pkg::ALU_OP_LITSUB) |=>
		s_reg.acc == 8'($past(lit) - $past(s_reg.acc))) else $error("literal subtract wrong");
	AST_CARRY: assert property (@(posedge hclk) disable iff (!hresetn)
		cmd_wr && op_raw == 4'(alu_pkg::ALU_OP_FILESUB) |=>
		s_reg.carry == ($past(s_reg.acc) <= $past(s_reg.file_data))) else $error("carry wrong");
	AST_NIB: assert property (@(posedge hclk) disable iff (!hresetn)
		cmd_wr && op_raw == 4'(alu_pkg::ALU_OP_FILESUB) |=>
		s_reg.nib == ($past(s_reg.acc[3:0]) <= $past(s_reg.file_data[3:0])))
		else $error("nibble carry wrong");
	AST_BORROW: assert property (@(posedge hclk) disable iff (!hresetn)
		cmd_wr && op_raw == 4'(alu_pkg::ALU_OP_FILESUBB) && !dest |=>
		s_reg.acc == 8'($past(s_reg.file_data) - $past(s_reg.acc) - 8'(!$past(s_reg.carry))))
		else $error("borrow subtract wrong");
	AST_SWAP: assert property (@(posedge hclk) disable iff (!hresetn)
		cmd_wr && op_raw == 4'(alu_pkg::ALU_OP_SWAP) |=> $stable(s_reg.carry)
		&& $stable(s_reg.zero) && $stable(s_reg.nib)) else $error("swap touched flags");
	AST_XORLIT: assert property (@(posedge hclk) disable iff (!hresetn)
		cmd_wr && op_raw == 4'(alu_pkg::ALU_OP_XORLIT) |=> $stable(s_reg.carry)
		&& s_reg.acc == ($past(s_reg.acc) ^ $past(lit))) else $error("xor literal wrong");
	AST_DIR: assert property (@(posedge hclk) disable iff (!hresetn)
		cmd_wr && op_raw == 4'(alu_pkg::ALU_OP_DIR) && lit == `ALU_DIR_B |=>
		s_reg.dir_b == $past(s_reg.acc) && $stable(s_reg.dir_a)) else $error("direction wrong");
	AST_XORFILE: assert property (@(posedge hclk) disable iff (!hresetn)
		cmd_wr && op_raw == 4'(alu_pkg::ALU_OP_XORFILE) && dest |=>
		s_reg.file_data == ($past(s_reg.acc) ^ $past(s_reg.file_data))) else $error("xor file");
	AST_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
		cmd_wr && op_raw == 4'(alu_pkg::ALU_OP_XORFILE) && !dest |=>
		s_reg.zero == (s_reg.acc == 8'h00)) else $error("zero flag wrong");
endmodule

// ===== tb/alu_wake_src.sv
`timescale 1ns/10ps
// ====================
// wake source on the far side of the low-power state
module alu_wake_src #(
	parameter int DELAY = 20
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic osc_stop,
	output logic wake
);
	logic [7:0] cnt_reg;
	// wake comes late on purpose, so the sleeping core can be probed first
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_reg <= 8'h00;
			wake <= 1'b0;
		end else if (!osc_stop) begin
			cnt_reg <= 8'h00;
			wake <= 1'b0;
		end else if (cnt_reg == 8'(DELAY)) begin
			wake <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end
endmodule

// ===== tb/tb.sv
`timescale 1ns/10ps
`include "alu_params.svh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin error_cnt++; \
	$display("wrong value %s expected %h seen %h", nm, ex, got); end end
// ====================
// bench top
module tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, wake, osc_stop, rd_phase = 1'b0;
	logic [31:0] exp_q[$];
	logic [31:0] mon_exp;
	int error_cnt = 0;
	int checks_done = 0;
	alu_pkg::alu_op_t ops[7] = '{alu_pkg::ALU_OP_ROTR, alu_pkg::ALU_OP_LITSUB,
		alu_pkg::ALU_OP_FILESUB, alu_pkg::ALU_OP_FILESUBB, alu_pkg::ALU_OP_SWAP,
		alu_pkg::ALU_OP_XORLIT, alu_pkg::ALU_OP_XORFILE};
	alu_pkg::alu_op_t op;
	logic [7:0] a, f, k, r, mn, ea, ef;
	logic [6:0] fa;
	logic [2:0] s;
	logic d, c, n, z;
	int diff, ndiff, bb;
	always #12.5 hclk = ~hclk;
	alu_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .wake(wake), .osc_stop(osc_stop));
	alu_wake_src #(.DELAY(20)) wsrc (.hclk(hclk), .hresetn(hresetn), .osc_stop(osc_stop),
		.wake(wake));
	// ====================
	// one single AHB transfer, held until hready is seen high
	task automatic xfer(input logic [7:0] ad, input logic wr, input logic [31:0] wd);
		haddr <= {24'h0, ad};
		htrans <= 2'h2;
		hwrite <= wr;
		hsel <= 1'b1;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		rd_phase <= !wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd_phase <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] ad, input logic [31:0] ex);
		exp_q.push_back(ex);
		xfer(ad, 1'b0, 32'h0);
	endtask
	task results;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// read data is taken at the edge that ends the data phase
	always @(posedge hclk) begin
		if (rd_phase && hreadyout === 1'b1) begin
			mon_exp = exp_q.pop_front();
			`CHK("read data", mon_exp, hrdata)
			`CHK("hresp", 1'b0, hresp)
		end
	end
	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge hclk);
		error_cnt++;
		results();
	end
	// ====================
	// main sequence
	initial begin
		void'($urandom(32'hfe95));
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(`ALU_OFF_STATUS, 32'h18);
		for (int j = 0; j < 3; j++) rd(`ALU_OFF_PORTA + 8'(4 * j), 32'hff);
		for (int i = 0; i < 42; i++) begin
			op = ops[i % 7];
			{a, f, k, fa, s, d} = 35'($urandom()) ^ {$urandom(), 3'h0};
			// equal operands hit the zero result and the carry boundary
			if (i % 3 == 0) {f, k} = {a, a};
			wr_all();
			ea = a;
			ef = f;
			{z, n, c} = s;
			bb = 0;
			case (op)
				alu_pkg::ALU_OP_ROTR: {r, c} = {s[0], f};
				alu_pkg::ALU_OP_SWAP: r = {f[3:0], f[7:4]};
				alu_pkg::ALU_OP_XORLIT: r = a ^ k;
				alu_pkg::ALU_OP_XORFILE: r = a ^ f;
				default: begin
					mn = (op == alu_pkg::ALU_OP_LITSUB) ? k : f;
					bb = (op == alu_pkg::ALU_OP_FILESUBB) ? int'(!s[0]) : 0;
					diff = int'(mn) - int'(a) - bb;
					ndiff = int'(mn[3:0]) - int'(a[3:0]) - bb;
					r = diff[7:0];
					c = diff >= 0;
					n = ndiff >= 0;
				end
			endcase
			if (op != alu_pkg::ALU_OP_ROTR && op != alu_pkg::ALU_OP_SWAP) z = (r == 8'h00);
			if (op == alu_pkg::ALU_OP_LITSUB || op == alu_pkg::ALU_OP_XORLIT || !d) ea = r;
			else ef = r;
			rd(`ALU_OFF_ACC, {24'h0, ea});
			rd(`ALU_OFF_FILE, {9'h0, fa, 8'h0, ef});
			rd(`ALU_OFF_STATUS, {26'h0, 3'b011, z, n, c});
		end
		// every direction operand in turn
		for (int j = 0; j < 3; j++) begin
			a = 8'($urandom());
			xfer(`ALU_OFF_ACC, 1'b1, {24'h0, a});
			xfer(`ALU_OFF_CMD, 1'b1, {16'h0, 8'h05 + 8'(j), 8'(alu_pkg::ALU_OP_DIR)});
			rd(`ALU_OFF_PORTA + 8'(4 * j), {24'h0, a});
		end
		xfer(`ALU_OFF_STATUS, 1'b1, 32'h0);
		xfer(`ALU_OFF_CMD, 1'b1, {28'h0, alu_pkg::ALU_OP_SLEEP});
		repeat (2) @(posedge hclk);
		#1;
		`CHK("osc_stop", 1'b1, osc_stop)
		rd(`ALU_OFF_STATUS, 32'h30);
		rd(`ALU_OFF_WDOG, 32'h0);
		// commands are refused while asleep
		xfer(`ALU_OFF_CMD, 1'b1, {16'h0, 8'hff, 8'(alu_pkg::ALU_OP_XORLIT)});
		rd(`ALU_OFF_ACC, {24'h0, a});
		for (int w = 0; w < 100 && osc_stop !== 1'b0; w++) @(posedge hclk);
		#1;
		`CHK("osc_stop", 1'b0, osc_stop)
		results();
	end
	task automatic wr_all;
		xfer(`ALU_OFF_ACC, 1'b1, {24'h0, a});
		xfer(`ALU_OFF_FILE, 1'b1, {17'h0, fa, f});
		xfer(`ALU_OFF_STATUS, 1'b1, {29'h0, s});
		xfer(`ALU_OFF_CMD, 1'b1, {16'h0, k, 3'h0, d, op});
	endtask
endmodule
